// ### include/tesc_regs.vh
// Register offsets, field positions and reset values of the tuner enable and sleep control block.
`ifndef TESC_REGS_VH
`define TESC_REGS_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define TESC_IDX_AUTO_TUNE      8'h14
`define TESC_IDX_OSC_SELECT     8'h18
`define TESC_IDX_TUNE_RESTART   8'h1c
`define TESC_IDX_AMP_BIAS_OFS   8'h20
`define TESC_IDX_SYS_ENABLES    8'h21
`define TESC_ADDR_W             10
`define TESC_ADDR_AUTO_TUNE     10'h050
`define TESC_ADDR_OSC_SELECT    10'h060
`define TESC_ADDR_TUNE_RESTART  10'h070
`define TESC_ADDR_AMP_BIAS_OFS  10'h080
`define TESC_ADDR_SYS_ENABLES   10'h084

// ****************************************************************
// Reset values
// ****************************************************************
`define TESC_RST_AUTO_TUNE      8'h00
`define TESC_RST_OSC_SELECT     8'h00
`define TESC_RST_AMP_BIAS_OFS   8'h00
`define TESC_RST_SYS_ENABLES    8'h00
`define TESC_RST_RESTART_READ   8'h10

// ****************************************************************
// Field positions and writable masks
// ****************************************************************
`define TESC_BIT_BIAS_DIS       3
`define TESC_OFS_LSB            1
`define TESC_BIT_RF_AMP         0
`define TESC_BIT_DC_CORR        2
`define TESC_BIT_BASEBAND       3
`define TESC_BIT_PRESCALER      4
`define TESC_BIT_CHARGE_PUMP    5
`define TESC_BIT_RESTART        4
`define TESC_MASK_SYS_ENABLES   8'h3d
`define TESC_MASK_AMP_BIAS_OFS  8'h0e
`define TESC_MASK_AUTO_TUNE     8'hc0
`define TESC_MASK_OSC_SELECT    8'hbf
`define TESC_RESP_OKAY          2'b00
`define TESC_RESP_SLVERR        2'b10

`endif

// ### src/tesc_ctrl.v
// Tuner enable and sleep control register bank behind an AXI4-Lite slave.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tesc_regs.vh"
// Summary of operation
// - The amp bias-control-disable bit at 0 lets unused gain stages lose bias, at 1 they keep it.
// - The two-bit amp offset field selects -70, -67, -64 or -61 dB for codes 00b to 11b.
// - The enable register resets to 00, D5 enables the charge pump, D4 the prescaler, D7, D6, D1 reserved.
// - Enable bit D3 turns the baseband section on.
// - Enable bit D2 turns DC offset correction on.
// - Enable bit D0 turns the RF amplifier on.
// - Tuning restart is write-only and a written 1 restarts the auto-tuning system.

module tesc_ctrl (
    input  wire        clk,
    input  wire        rst,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         amp_bias_ctrl_disable,
    output reg  [1:0]  amp_offset_select,
    output reg         charge_pump_on,
    output reg         prescaler_on,
    output reg         baseband_on,
    output reg         dc_correction_on,
    output reg         rf_amp_on,
    output reg  [1:0]  auto_tune_enable_field,
    output reg  [6:0]  oscillator_select,
    output reg         tuning_restart
);

// ****************************************************************
// Register storage
// ****************************************************************
reg  [7:0]  auto_tune_r;
reg  [7:0]  osc_select_r;
reg  [7:0]  amp_bias_ofs_r;
reg  [7:0]  sys_enables_r;

// Next values of the register bank and of the read answer.
reg  [7:0]  auto_tune_nxt;
reg  [7:0]  osc_select_nxt;
reg  [7:0]  amp_bias_ofs_nxt;
reg  [7:0]  sys_enables_nxt;
reg         restart_nxt;
reg  [31:0] rdata_nxt;
reg  [1:0]  rresp_nxt;

// Write-channel state: each half of a write is held here until both are present.
reg  [9:0]  awaddr_r;
reg         aw_held_r;
reg  [7:0]  wdata_r;
reg         wlane_r;
reg         w_held_r;

// Next values of the write-channel state and of its handshake outputs.
reg         awready_nxt;
reg         wready_nxt;
reg         bvalid_nxt;
reg  [1:0]  bresp_nxt;
reg         aw_held_nxt;
reg         w_held_nxt;
reg  [9:0]  awaddr_nxt;
reg  [7:0]  wdata_nxt;
reg         wlane_nxt;

wire        wr_go;
wire        wr_store;
wire        wr_hit;
wire [7:0]  wbyte;
wire [7:0]  wr_index;
wire [7:0]  rd_index;
wire        sel_auto_tune;
wire        sel_osc_select;
wire        sel_restart;
wire        sel_amp_bias_ofs;
wire        sel_sys_enables;

// ****************************************************************
// Write channel: address and data captured in either order
// ****************************************************************
// A write completes once both halves are held and the previous response has been taken.
assign wr_go    = aw_held_r && w_held_r && !s_axi_bvalid;
// Only byte lane 0 carries register data; with its strobe low the write is answered but not stored.
assign wr_store = wr_go && wlane_r;
assign wbyte    = wdata_r;

// Registers decode on the word index, so the two low address bits are ignored.
assign wr_index = awaddr_r[9:2];
assign rd_index = s_axi_araddr[9:2];

assign sel_auto_tune    = (wr_index == `TESC_IDX_AUTO_TUNE);
assign sel_osc_select   = (wr_index == `TESC_IDX_OSC_SELECT);
assign sel_restart      = (wr_index == `TESC_IDX_TUNE_RESTART);
assign sel_amp_bias_ofs = (wr_index == `TESC_IDX_AMP_BIAS_OFS);
assign sel_sys_enables  = (wr_index == `TESC_IDX_SYS_ENABLES);
// An address outside the map is answered with an error and changes nothing.
assign wr_hit           = sel_auto_tune || sel_osc_select || sel_restart ||
                          sel_amp_bias_ofs || sel_sys_enables;

always @* begin
    // While idle, ready toggles so that a taken half is never taken twice in a row.
    awready_nxt = !aw_held_r && !s_axi_awready;
    wready_nxt  = !w_held_r && !s_axi_wready;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
        aw_held_nxt = 1'b1;
        awaddr_nxt  = s_axi_awaddr;
        awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
        w_held_nxt  = 1'b1;
        wdata_nxt   = s_axi_wdata[7:0];
        wlane_nxt   = s_axi_wstrb[0];
        wready_nxt  = 1'b0;
    end
    if (wr_go) begin
        aw_held_nxt = 1'b0;
        w_held_nxt  = 1'b0;
        bvalid_nxt  = 1'b1;
        bresp_nxt   = wr_hit ? `TESC_RESP_OKAY : `TESC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
        bvalid_nxt  = 1'b0;
    end
end

// Handshake registers; a response stays up until the master takes it.
always @(posedge clk) begin
    if (rst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `TESC_RESP_OKAY;
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        awaddr_r      <= 10'h000;
        wdata_r       <= 8'h00;
        wlane_r       <= 1'b0;
    end else begin
        s_axi_awready <= awready_nxt;
        s_axi_wready  <= wready_nxt;
        s_axi_bvalid  <= bvalid_nxt;
        s_axi_bresp   <= bresp_nxt;
        aw_held_r     <= aw_held_nxt;
        w_held_r      <= w_held_nxt;
        awaddr_r      <= awaddr_nxt;
        wdata_r       <= wdata_nxt;
        wlane_r       <= wlane_nxt;
    end
end

// ****************************************************************
// Register updates and the restart pulse
// ****************************************************************
always @* begin
    auto_tune_nxt    = auto_tune_r;
    osc_select_nxt   = osc_select_r;
    amp_bias_ofs_nxt = amp_bias_ofs_r;
    sys_enables_nxt  = sys_enables_r;
    restart_nxt      = 1'b0;
    if (wr_store) begin
        // Reserved bit positions are masked so that they always hold zero.
        if (sel_auto_tune) begin
            auto_tune_nxt = wbyte & `TESC_MASK_AUTO_TUNE;
        end
        if (sel_osc_select) begin
            osc_select_nxt = wbyte & `TESC_MASK_OSC_SELECT;
        end
        if (sel_amp_bias_ofs) begin
            amp_bias_ofs_nxt = wbyte & `TESC_MASK_AMP_BIAS_OFS;
        end
        if (sel_sys_enables) begin
            sys_enables_nxt = wbyte & `TESC_MASK_SYS_ENABLES;
        end
        if (sel_restart) begin
            // Nothing is stored: a written 1 becomes a single-cycle restart pulse.
            restart_nxt = wbyte[`TESC_BIT_RESTART];
        end
    end
end

// The bank changes at the same edge at which the write response rises.
always @(posedge clk) begin
    if (rst) begin
        auto_tune_r    <= `TESC_RST_AUTO_TUNE;
        osc_select_r   <= `TESC_RST_OSC_SELECT;
        amp_bias_ofs_r <= `TESC_RST_AMP_BIAS_OFS;
        sys_enables_r  <= `TESC_RST_SYS_ENABLES;
        tuning_restart <= 1'b0;
    end else begin
        auto_tune_r    <= auto_tune_nxt;
        osc_select_r   <= osc_select_nxt;
        amp_bias_ofs_r <= amp_bias_ofs_nxt;
        sys_enables_r  <= sys_enables_nxt;
        tuning_restart <= restart_nxt;
    end
end

// ****************************************************************
// Control outputs, one flop each
// ****************************************************************
// Each control output copies its field one cycle after the register changes.
always @(posedge clk) begin
    if (rst) begin
        amp_bias_ctrl_disable  <= 1'b0;
        amp_offset_select      <= 2'b00;
        charge_pump_on         <= 1'b0;
        prescaler_on           <= 1'b0;
        baseband_on            <= 1'b0;
        dc_correction_on       <= 1'b0;
        rf_amp_on              <= 1'b0;
        auto_tune_enable_field <= 2'b00;
        oscillator_select      <= 7'h00;
    end else begin
        amp_bias_ctrl_disable  <= amp_bias_ofs_r[`TESC_BIT_BIAS_DIS];
        amp_offset_select      <= amp_bias_ofs_r[`TESC_OFS_LSB +: 2];
        charge_pump_on         <= sys_enables_r[`TESC_BIT_CHARGE_PUMP];
        prescaler_on           <= sys_enables_r[`TESC_BIT_PRESCALER];
        baseband_on            <= sys_enables_r[`TESC_BIT_BASEBAND];
        dc_correction_on       <= sys_enables_r[`TESC_BIT_DC_CORR];
        rf_amp_on              <= sys_enables_r[`TESC_BIT_RF_AMP];
        auto_tune_enable_field <= auto_tune_r[7:6];
        oscillator_select      <= {osc_select_r[7], osc_select_r[5:0]};
    end
end

// ****************************************************************
// Read channel
// ****************************************************************
// The read word is selected from the address on the bus and captured at the handshake.
always @* begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = `TESC_RESP_OKAY;
    case (rd_index)
        `TESC_IDX_AUTO_TUNE: begin
            rdata_nxt = {24'h000000, auto_tune_r};
        end
        `TESC_IDX_OSC_SELECT: begin
            rdata_nxt = {24'h000000, osc_select_r};
        end
        `TESC_IDX_AMP_BIAS_OFS: begin
            rdata_nxt = {24'h000000, amp_bias_ofs_r};
        end
        `TESC_IDX_SYS_ENABLES: begin
            rdata_nxt = {24'h000000, sys_enables_r};
        end
        `TESC_IDX_TUNE_RESTART: begin
            // The restart bit is write-only, so this word reads as zero.
            rdata_nxt = 32'h00000000;
        end
        default: begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = `TESC_RESP_SLVERR;
        end
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `TESC_RESP_OKAY;
    end else begin
        // Ready is offered only while no read answer is pending.
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // tesc_ctrl
`default_nettype wire

// ### test/tesc_ctrl_sva.sv
// Assertion checker of the tuner enable and sleep control register bank.
`timescale 1ns/1ps
`default_nettype none
module tesc_ctrl_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        charge_pump_on,
    input wire logic        rf_amp_on,
    input wire logic        tuning_restart
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("late bvalid");
    AST_RST_CLEAR: assert property ($fell(rst) |-> !charge_pump_on && !rf_amp_on && !tuning_restart)
        else $error("outputs not cleared");
    AST_PULSE_ONE: assert property (tuning_restart |=> !tuning_restart) else $error("long restart");
    AST_PULSE_CAUSE: assert property (tuning_restart |-> $rose(s_axi_bvalid)) else $error("stray restart");
    AST_EN_CAUSE: assert property ($changed({charge_pump_on, rf_amp_on}) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("enable moved without write");
endmodule // tesc_ctrl_sva
bind tesc_ctrl tesc_ctrl_sva u_sva (.*);
`default_nettype wire

// ### test/tesc_ctrl_tb.sv
// Self-checking testbench of the tuner enable and sleep control register bank.
`timescale 1ns/1ps
`default_nettype none
`include "tesc_regs.vh"
module tesc_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, amp_bias_ctrl_disable, charge_pump_on, prescaler_on;
    logic        baseband_on, dc_correction_on, rf_amp_on, tuning_restart;
    logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, amp_offset_select, auto_tune_enable_field, r;
    logic [6:0]  oscillator_select;
    logic [7:0]  m [4] = '{4{8'h00}};
    logic [9:0]  ad [4] = '{`TESC_ADDR_AUTO_TUNE, `TESC_ADDR_OSC_SELECT, `TESC_ADDR_AMP_BIAS_OFS, `TESC_ADDR_SYS_ENABLES};
    logic [7:0]  mk [4] = '{`TESC_MASK_AUTO_TUNE, `TESC_MASK_OSC_SELECT, `TESC_MASK_AMP_BIAS_OFS, `TESC_MASK_SYS_ENABLES};
    int          bad_count = 0, checked = 0, pulses = 0, p0, i;
    tesc_ctrl u_dut (.*);
    always #2 clk = ~clk;
    always @(posedge clk) if (tuning_restart === 1'b1) pulses <= pulses + 1;
    // ********
    // Helpers
    // ********
    function automatic logic [16:0] got();
        return {auto_tune_enable_field, oscillator_select, amp_bias_ctrl_disable, amp_offset_select,
                charge_pump_on, prescaler_on, baseband_on, dc_correction_on, rf_amp_on};
    endfunction
    function automatic logic [16:0] want();
        return {m[0][7:6], m[1][7], m[1][5:0], m[2][3:1], m[3][5:2], m[3][0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where the values of the next rising edge already stand.
    task automatic wr(input logic [9:0] a, input logic [7:0] v, input logic [3:0] s);
        logic ha, hw, hb;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (hb !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        logic ha, hr;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ha = s_axi_arvalid & s_axi_arready;
            hr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ha) s_axi_arvalid <= 1'b0;
        end while (hr !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic put(input int k, input logic [7:0] v, input logic [3:0] s);
        wr(ad[k], v, s);
        if (s[0]) m[k] = v & mk[k];
        chk("bresp", r, `TESC_RESP_OKAY);
        rd(ad[k]);
        chk("readback", d, {24'h0, m[k]});
        chk("outputs", got(), want());
    endtask
    task automatic reset_check;
        foreach (ad[k]) begin
            rd(ad[k]);
            chk("reset value", d, 0);
        end
        chk("reset outputs", got(), 0);
    endtask
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h04b0bc9f));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        $display("test reset done");
        for (int k = 0; k < 40; k++) put(k < 4 ? k : $urandom % 4, k < 4 ? 8'hff : $urandom, k < 4 ? 4'hf : $urandom);
        $display("test random done");
        put(2, 8'h00, 4'hf);
        chk("large signal offset", amp_offset_select, 2'b00);
        put(2, 8'h0c, 4'hf);
        chk("small signal offset", amp_offset_select, 2'b10);
        put(2, 8'h08, 4'hf);
        chk("bias only", {amp_bias_ctrl_disable, amp_offset_select}, 3'b100);
        put(0, 8'h40, 4'hf);
        put(1, 8'h00, 4'hf);
        put(3, 8'h00, 4'hf);
        chk("sleep enables", {charge_pump_on, prescaler_on, baseband_on, dc_correction_on, rf_amp_on}, 0);
        put(0, 8'h40, 4'hf);
        put(3, 8'h3f, 4'hf);
        chk("wake enables", {charge_pump_on, prescaler_on, baseband_on, dc_correction_on, rf_amp_on}, 5'h1f);
        p0 = pulses;
        wr(`TESC_ADDR_TUNE_RESTART, 8'h10, 4'hf);
        wr(`TESC_ADDR_TUNE_RESTART, 8'h00, 4'hf);
        rd(`TESC_ADDR_TUNE_RESTART);
        chk("restart read", d, 0);
        chk("restart pulses", pulses - p0, 1);
        $display("test sleep done");
        wr(10'h3fc, 8'hff, 4'hf);
        chk("unmapped bresp", r, `TESC_RESP_SLVERR);
        rd(10'h3fc);
        chk("unmapped rresp", r, `TESC_RESP_SLVERR);
        chk("unmapped data", d, 0);
        chk("outputs kept", got(), want());
        $display("test unmapped done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        m = '{4{8'h00}};
        reset_check();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule // tesc_ctrl_tb
`default_nettype wire
